// ### include/mssc_pkg.sv
// Package: register map, field positions, reset values and codes of the status and serial bank
package mssc_pkg;

    // ********************************************************
    // Register offsets (register index on the serial link)
    // ********************************************************
    localparam logic [15:0] MSSC_OFF_OPMODE = 16'h0001;
    localparam logic [15:0] MSSC_OFF_STATUS_LO = 16'h0002;
    localparam logic [15:0] MSSC_OFF_STATUS_HI = 16'h0003;
    localparam logic [15:0] MSSC_OFF_NODE_ADDR = 16'h0004;
    localparam logic [15:0] MSSC_OFF_BITRATE_SEL = 16'h0005;
    localparam logic [15:0] MSSC_OFF_PARITY_SEL = 16'h0006;
    localparam logic [15:0] MSSC_OFF_BITRATE_CUR = 16'h0007;

    // ********************************************************
    // Status word bit positions
    // ********************************************************
    localparam int MSSC_ST_FB_RUN = 0;
    localparam int MSSC_ST_SSC_RUN = 1;
    localparam int MSSC_ST_SSC_MAP_ERR = 2;
    localparam int MSSC_ST_SDP_MAP_ERR = 3;
    localparam int MSSC_ST_FB_MAP_ERR = 4;
    localparam int MSSC_ST_SSC_CFG_ERR = 5;
    localparam int MSSC_ST_SDP_CFG_ERR = 6;
    localparam int MSSC_ST_FB_CFG_ERR = 7;
    localparam int MSSC_ST_EXT_MAP_ERR = 14;
    localparam int MSSC_ST_SCRIPT_RUN = 15;
    localparam int MSSC_ST_SCRIPT_ERR = 16;

    // ********************************************************
    // Reset values, limits and codes
    // ********************************************************
    localparam logic [7:0] MSSC_NODE_ADDR_RST = 8'h01;
    localparam logic [7:0] MSSC_NODE_ADDR_MIN = 8'h01;
    localparam logic [7:0] MSSC_NODE_ADDR_MAX = 8'hF7;
    localparam logic [7:0] MSSC_BITRATE_RST = 8'h00;
    localparam logic [7:0] MSSC_BITRATE_MAX = 8'h07;
    localparam logic [7:0] MSSC_PARITY_RST = 8'h00;
    localparam logic [7:0] MSSC_PARITY_MAX = 8'h02;
    localparam logic [15:0] MSSC_OPMODE_RST = 16'h0000;
    localparam logic [15:0] MSSC_OPMODE_MAX = 16'h0003;
    localparam logic [15:0] MSSC_OPMODE_RESET = 16'h0003;
    localparam logic [2:0] MSSC_RATE_AUTO = 3'h0;
    localparam logic [2:0] MSSC_RATE_FIRST = 3'h1;
    localparam logic [2:0] MSSC_RATE_LAST = 3'h7;
    localparam logic [1:0] MSSC_PAR_EVEN = 2'h0;
    localparam logic [1:0] MSSC_PAR_ODD = 2'h1;
    localparam logic [1:0] MSSC_PAR_NONE = 2'h2;
    localparam logic [15:0] MSSC_UNMAPPED_DATA = 16'h0000;

    // Parity mode carried to the serial engine
    typedef enum logic [1:0] {
        MSSC_PM_EVEN = 2'b00,
        MSSC_PM_ODD = 2'b01,
        MSSC_PM_NONE = 2'b11
    } mssc_parity_t;

    // Bitrate tracker state, Gray along idle -> hunt -> locked -> fixed
    typedef enum logic [1:0] {
        MSSC_BR_IDLE = 2'b00,
        MSSC_BR_HUNT = 2'b01,
        MSSC_BR_LOCK = 2'b11,
        MSSC_BR_FIXED = 2'b10
    } mssc_br_state_t;

endpackage

// ### logic/mssc_cfg_mem.sv
// Small nonvolatile-style store for the three serial settings, registered read data
`timescale 1ns/1ps
module mssc_cfg_mem
    import mssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [1:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [7:0] node_addr,
    output logic [7:0] bitrate_sel,
    output logic [7:0] parity_sel
);

    // ********************************************************
    // Storage words
    // ********************************************************
    logic [7:0] mem_r [0:2]; // Node address, bitrate, parity
    logic [7:0] mem_nxt [0:2]; // Next contents
    logic [7:0] rd_r; // Registered read word
    logic [7:0] rd_nxt; // Next read word

    // Write port and read mux
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (wr_en && wr_idx != 2'd3) begin
            mem_nxt[wr_idx] = wr_data;
        end
        rd_nxt = (rd_idx == 2'd3) ? 8'h00 : mem_r[rd_idx];
    end

    // Registers, with documented defaults at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r[0] <= MSSC_NODE_ADDR_RST;
            mem_r[1] <= MSSC_BITRATE_RST;
            mem_r[2] <= MSSC_PARITY_RST;
            rd_r <= 8'h00;
        end else begin
            for (int i = 0; i < 3; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
            rd_r <= rd_nxt;
        end
    end

    assign rd_data = rd_r;
    assign node_addr = mem_r[0];
    assign bitrate_sel = mem_r[1];
    assign parity_sel = mem_r[2];

endmodule // mssc_cfg_mem

// ### logic/mssc_rate_track.sv
// Bitrate tracker: fixed rate or stepping hunt until a valid frame locks it
`timescale 1ns/1ps
module mssc_rate_track
    import mssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic apply,
    input wire logic [2:0] sel_code,
    input wire logic frame_ok,
    input wire logic frame_bad,
    output logic [2:0] rate_use,
    output logic [2:0] rate_cur
);

    // ********************************************************
    // State
    // ********************************************************
    mssc_br_state_t st_r; // Tracker state
    mssc_br_state_t st_nxt; // Next state
    logic [2:0] try_r; // Rate in use on the line
    logic [2:0] try_nxt; // Next rate

    // Next state: auto hunts from the lowest rate, wraps after the highest
    always_comb begin
        st_nxt = st_r;
        try_nxt = try_r;
        if (apply) begin
            if (sel_code == MSSC_RATE_AUTO) begin
                st_nxt = MSSC_BR_HUNT;
                try_nxt = MSSC_RATE_FIRST;
            end else begin
                st_nxt = MSSC_BR_FIXED;
                try_nxt = sel_code;
            end
        end else begin
            case (st_r)
                MSSC_BR_HUNT: begin
                    if (frame_ok) begin
                        st_nxt = MSSC_BR_LOCK;
                    end else if (frame_bad) begin
                        try_nxt = (try_r == MSSC_RATE_LAST) ? MSSC_RATE_FIRST
                                                            : 3'(try_r + 3'd1);
                    end
                end
                default: begin
                    st_nxt = st_r;
                end
            endcase
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= MSSC_BR_IDLE;
            try_r <= MSSC_RATE_AUTO;
        end else begin
            st_r <= st_nxt;
            try_r <= try_nxt;
        end
    end

    assign rate_use = try_r;
    // Readback zero until settled
    assign rate_cur = (st_r == MSSC_BR_LOCK || st_r == MSSC_BR_FIXED) ? try_r
                                                                     : MSSC_RATE_AUTO;

endmodule // mssc_rate_track

// ### logic/mssc_regs.sv
// Module status and serial data port configuration register bank
`timescale 1ns/1ps
module mssc_regs
    import mssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // Register access from the serial protocol engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Status sources
    input wire logic fb_run,
    input wire logic ssc_run,
    input wire logic ssc_map_err,
    input wire logic sdp_map_err,
    input wire logic fb_map_err,
    input wire logic ssc_cfg_err,
    input wire logic sdp_cfg_err,
    input wire logic fb_cfg_err,
    input wire logic ext_map_err,
    input wire logic script_run,
    input wire logic script_err,
    input wire logic init_busy,
    // Frame outcome from the receiver
    input wire logic frame_ok,
    input wire logic frame_bad,
    // Settings in force on the serial port, and the module reset request
    output logic [7:0] sdp_node_addr,
    output logic [2:0] sdp_rate,
    output logic [1:0] sdp_parity,
    output logic sdp_two_stop,
    output logic sdp_reply_en,
    output logic module_reset
);

    // ********************************************************
    // Functions
    // ********************************************************
    // Parity code to mode; out of range falls back to even
    function automatic mssc_parity_t par_decode(input logic [7:0] c);
        if (c == {6'h00, MSSC_PAR_ODD}) begin
            return MSSC_PM_ODD;
        end else if (c == {6'h00, MSSC_PAR_NONE}) begin
            return MSSC_PM_NONE;
        end
        return MSSC_PM_EVEN;
    endfunction

    // Range check for a written byte
    function automatic logic in_range(input logic [15:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (v[15:8] == 8'h00) && (v[7:0] >= lo) && (v[7:0] <= hi);
    endfunction

    // ********************************************************
    // Declarations
    // ********************************************************
    logic [31:0] stat_r; // Live status word
    logic [31:0] stat_nxt; // Next status word
    logic ssc_cfg_r; // Bit 5 latched at init
    logic ssc_cfg_nxt; // Next bit 5
    logic [15:0] opmode_r; // Operating mode register
    logic [15:0] opmode_nxt; // Next operating mode
    logic apply_r; // Pending settings take effect
    logic apply_nxt; // Next apply pulse
    logic boot_r; // Settings applied once after power up
    logic [7:0] act_addr_r; // Node address in force
    logic [7:0] act_addr_nxt; // Next address in force
    mssc_parity_t act_par_r; // Parity in force
    mssc_parity_t act_par_nxt; // Next parity in force
    logic [15:0] rdata_r; // Read data register
    logic [15:0] rdata_nxt; // Next read data
    logic rvalid_r; // Read answer strobe
    logic rd_mem_r; // Read request pending, any register
    logic [15:0] rd_addr_r; // Address of pending read
    logic mem_wr; // Store write enable
    logic [1:0] mem_widx; // Store write index
    logic [1:0] mem_ridx; // Store read index
    logic [7:0] mem_rdata; // Store read data
    logic [7:0] cfg_addr; // Stored node address
    logic [7:0] cfg_rate; // Stored bitrate select
    logic [7:0] cfg_par; // Stored parity select
    logic [2:0] rate_use; // Rate driving the line
    logic [2:0] rate_cur; // Rate readback
    logic [2:0] rate_cur_r; // Registered readback
    logic reset_r; // Module reset request

    // ********************************************************
    // Submodules
    // ********************************************************
    // Settings store
    mssc_cfg_mem u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(mem_wr),
        .wr_idx(mem_widx),
        .wr_data(reg_wdata[7:0]),
        .rd_idx(mem_ridx),
        .rd_data(mem_rdata),
        .node_addr(cfg_addr),
        .bitrate_sel(cfg_rate),
        .parity_sel(cfg_par)
    );

    // Bitrate tracker, loaded only on apply
    mssc_rate_track u_rate (
        .clk(clk),
        .rst_n(rst_n),
        .apply(apply_r),
        .sel_code(cfg_rate[2:0]),
        .frame_ok(frame_ok),
        .frame_bad(frame_bad),
        .rate_use(rate_use),
        .rate_cur(rate_cur)
    );

    // ********************************************************
    // Status word
    // ********************************************************
    always_comb begin
        stat_nxt = 32'h0000_0000; // Reserved bits stay zero
        stat_nxt[MSSC_ST_FB_RUN] = fb_run;
        stat_nxt[MSSC_ST_SSC_RUN] = ssc_run;
        stat_nxt[MSSC_ST_SSC_MAP_ERR] = ssc_map_err;
        stat_nxt[MSSC_ST_SDP_MAP_ERR] = sdp_map_err;
        stat_nxt[MSSC_ST_FB_MAP_ERR] = fb_map_err;
        stat_nxt[MSSC_ST_SSC_CFG_ERR] = ssc_cfg_r;
        stat_nxt[MSSC_ST_SDP_CFG_ERR] = sdp_cfg_err;
        stat_nxt[MSSC_ST_FB_CFG_ERR] = fb_cfg_err;
        stat_nxt[MSSC_ST_EXT_MAP_ERR] = ext_map_err;
        stat_nxt[MSSC_ST_SCRIPT_RUN] = script_run;
        stat_nxt[MSSC_ST_SCRIPT_ERR] = script_err;
        // Bit 5 is sampled only while the module initialises
        ssc_cfg_nxt = init_busy ? ssc_cfg_err : ssc_cfg_r;
    end

    // ********************************************************
    // Register writes
    // ********************************************************
    always_comb begin
        opmode_nxt = opmode_r;
        apply_nxt = 1'b0;
        mem_wr = 1'b0;
        mem_widx = 2'd0;
        if (reg_wr) begin
            if (reg_addr == MSSC_OFF_OPMODE) begin
                if (in_range(reg_wdata, 8'h00, MSSC_OPMODE_MAX[7:0])) begin
                    opmode_nxt = reg_wdata;
                end
                apply_nxt = (reg_wdata == MSSC_OPMODE_RESET);
            end else if (reg_addr == MSSC_OFF_NODE_ADDR) begin
                mem_wr = in_range(reg_wdata, MSSC_NODE_ADDR_MIN, MSSC_NODE_ADDR_MAX);
                mem_widx = 2'd0;
            end else if (reg_addr == MSSC_OFF_BITRATE_SEL) begin
                mem_wr = in_range(reg_wdata, 8'h00, MSSC_BITRATE_MAX);
                mem_widx = 2'd1;
            end else if (reg_addr == MSSC_OFF_PARITY_SEL) begin
                mem_wr = in_range(reg_wdata, 8'h00, MSSC_PARITY_MAX);
                mem_widx = 2'd2;
            end else begin
                mem_wr = 1'b0; // Status and readback are not writable
            end
        end
        if (!boot_r) begin
            apply_nxt = 1'b1; // Power-up applies stored settings
        end
        if (apply_r) begin
            opmode_nxt = MSSC_OPMODE_RST;
        end
    end

    // Settings in force change only on apply
    always_comb begin
        act_addr_nxt = act_addr_r;
        act_par_nxt = act_par_r;
        if (apply_r) begin
            act_addr_nxt = cfg_addr;
            act_par_nxt = par_decode(cfg_par);
        end
    end

    // ********************************************************
    // Register reads
    // ********************************************************
    always_comb begin
        mem_ridx = 2'd3;
        if (reg_addr == MSSC_OFF_NODE_ADDR) begin
            mem_ridx = 2'd0;
        end else if (reg_addr == MSSC_OFF_BITRATE_SEL) begin
            mem_ridx = 2'd1;
        end else if (reg_addr == MSSC_OFF_PARITY_SEL) begin
            mem_ridx = 2'd2;
        end
        if (rd_addr_r == MSSC_OFF_OPMODE) begin
            rdata_nxt = opmode_r;
        end else if (rd_addr_r == MSSC_OFF_STATUS_LO) begin
            rdata_nxt = stat_r[15:0];
        end else if (rd_addr_r == MSSC_OFF_STATUS_HI) begin
            rdata_nxt = stat_r[31:16];
        end else if (rd_addr_r == MSSC_OFF_BITRATE_CUR) begin
            rdata_nxt = {13'h0000, rate_cur_r};
        end else if (rd_addr_r == MSSC_OFF_NODE_ADDR || rd_addr_r == MSSC_OFF_BITRATE_SEL
                     || rd_addr_r == MSSC_OFF_PARITY_SEL) begin
            rdata_nxt = {8'h00, mem_rdata};
        end else begin
            rdata_nxt = MSSC_UNMAPPED_DATA;
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= 32'h0000_0000;
            ssc_cfg_r <= 1'b0;
            opmode_r <= MSSC_OPMODE_RST;
            apply_r <= 1'b0;
            boot_r <= 1'b0;
            act_addr_r <= MSSC_NODE_ADDR_RST;
            act_par_r <= MSSC_PM_EVEN;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
            rd_mem_r <= 1'b0;
            rd_addr_r <= 16'h0000;
            rate_cur_r <= MSSC_RATE_AUTO;
            reset_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            ssc_cfg_r <= ssc_cfg_nxt;
            opmode_r <= opmode_nxt;
            apply_r <= apply_nxt;
            boot_r <= 1'b1;
            act_addr_r <= act_addr_nxt;
            act_par_r <= act_par_nxt;
            rd_mem_r <= reg_rd;
            rd_addr_r <= reg_rd ? reg_addr : rd_addr_r;
            rdata_r <= rd_mem_r ? rdata_nxt : rdata_r;
            rvalid_r <= rd_mem_r;
            rate_cur_r <= rate_cur;
            reset_r <= apply_nxt && boot_r;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    logic [2:0] rate_r; // Rate on the line, registered
    logic two_stop_r; // Stop count in force
    logic reply_r; // Replies allowed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_r <= MSSC_RATE_AUTO;
            two_stop_r <= 1'b0;
            reply_r <= 1'b0;
        end else begin
            rate_r <= rate_use;
            two_stop_r <= (act_par_r == MSSC_PM_NONE);
            reply_r <= (rate_cur != MSSC_RATE_AUTO);
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign sdp_node_addr = act_addr_r; // Receiver matches first frame byte
    assign sdp_rate = rate_r;
    assign sdp_parity = act_par_r;
    assign sdp_two_stop = two_stop_r;
    assign sdp_reply_en = reply_r;
    assign module_reset = reset_r;

    // ********************************************************
    // Assertions
    // ********************************************************
    property p_fb_run;
        @(posedge clk) disable iff (!rst_n) $changed(fb_run) |=> stat_r[MSSC_ST_FB_RUN] == $past(fb_run);
    endproperty
    a_fb_run: assert property (p_fb_run) else $error("run bit not tracking");

    property p_reserved;
        @(posedge clk) disable iff (!rst_n) stat_r[13:8] == 6'h00 && stat_r[31:17] == 15'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bits set");

    property p_bit5_hold;
        @(posedge clk) disable iff (!rst_n) !init_busy |=> $stable(ssc_cfg_r);
    endproperty
    a_bit5_hold: assert property (p_bit5_hold) else $error("bit5 changed after init");

    property p_hi_word;
        @(posedge clk) disable iff (!rst_n)
            reg_rd && reg_addr == MSSC_OFF_STATUS_HI
            |=> ##1 reg_rvalid && reg_rdata == $past(stat_r[31:16]);
    endproperty
    a_hi_word: assert property (p_hi_word) else $error("high status word wrong");

    property p_addr_range;
        @(posedge clk) disable iff (!rst_n) cfg_addr >= MSSC_NODE_ADDR_MIN && cfg_addr <= MSSC_NODE_ADDR_MAX;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("node address out of range");

    property p_apply_only;
        @(posedge clk) disable iff (!rst_n) !apply_r |=> $stable(act_addr_r) && $stable(act_par_r);
    endproperty
    a_apply_only: assert property (p_apply_only) else $error("setting applied without reset");

    property p_stop;
        @(posedge clk) disable iff (!rst_n) ##1 (sdp_two_stop == ($past(sdp_parity) == MSSC_PM_NONE));
    endproperty
    a_stop: assert property (p_stop) else $error("stop bits mismatch parity");

    property p_no_reply;
        @(posedge clk) disable iff (!rst_n) sdp_reply_en |-> $past(rate_cur) != MSSC_RATE_AUTO;
    endproperty
    a_no_reply: assert property (p_no_reply) else $error("reply before rate known");

    property p_ro_write;
        @(posedge clk) disable iff (!rst_n)
            reg_wr && (reg_addr == MSSC_OFF_STATUS_LO || reg_addr == MSSC_OFF_BITRATE_CUR) |-> !mem_wr;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only register written");

    c_reset: cover property (@(posedge clk) module_reset);
    c_lock: cover property (@(posedge clk) $rose(sdp_reply_en));
    c_read: cover property (@(posedge clk) reg_rvalid && reg_rdata != 16'h0000);

endmodule // mssc_regs

// ### testbench/mssc_master_model.sv
// Partner model: serial master that polls until the device rate matches its own
`timescale 1ns/1ps
module mssc_master_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [2:0] want,
    input wire logic [2:0] dev_rate,
    output logic frame_ok,
    output logic frame_bad,
    output int polls
);
    logic hit;
    // Each poll is one request frame to the node address in force
    initial begin
        frame_ok = 1'b0;
        frame_bad = 1'b0;
        polls = 0;
        hit = 1'b0;
        forever begin
            @(posedge clk);
            // Poll again while unanswered, 40 times at most
            if (go && !hit && polls < 40) begin
                repeat (3) @(posedge clk);
                hit = (dev_rate == want);
                frame_ok <= hit;
                frame_bad <= !hit;
                polls++;
                @(posedge clk);
                frame_ok <= 1'b0;
                frame_bad <= 1'b0;
            end
        end
    end
endmodule // mssc_master_model

// ### testbench/test_module_status_serial_config_regs.sv
// Bench for the module status and serial port register bank
`timescale 1ns/1ps
module test_module_status_serial_config_regs;
    import mssc_pkg::*;
    typedef struct {logic we; logic [15:0] a; logic [15:0] d; logic [15:0] e;} mssc_row_t;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, init_busy = 1, go = 0;
    logic reg_rvalid, sdp_two_stop, sdp_reply_en, module_reset, frame_ok, frame_bad;
    logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [31:0] ex;
    logic [10:0] st = 11'h020;
    logic [7:0] sdp_node_addr;
    logic [2:0] sdp_rate;
    logic [1:0] sdp_parity;
    int num_errors, checks, polls, n;
    // Rows: write enable, address, write data, expected read
    mssc_row_t rows[12] = '{'{0, 4, 0, 1}, '{0, 5, 0, 0}, '{0, 6, 0, 0}, '{1, 4, 'hF7, 'hF7},
        '{1, 4, 'hF8, 'hF7}, '{1, 4, 0, 'hF7}, '{1, 5, 7, 7}, '{1, 5, 8, 7}, '{1, 6, 3, 0},
        '{1, 7, 3, 4}, '{1, 2, 'hFFFF, 'h20}, '{1, 9, 1, 0}};
    always #2 clk = ~clk;
    mssc_regs u_dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .fb_run(st[0]), .ssc_run(st[1]), .ssc_map_err(st[2]),
        .sdp_map_err(st[3]), .fb_map_err(st[4]), .ssc_cfg_err(st[5]), .sdp_cfg_err(st[6]),
        .fb_cfg_err(st[7]), .ext_map_err(st[8]), .script_run(st[9]), .script_err(st[10]),
        .init_busy, .frame_ok, .frame_bad, .sdp_node_addr, .sdp_rate, .sdp_parity,
        .sdp_two_stop, .sdp_reply_en, .module_reset);
    mssc_master_model u_master (.clk, .go, .want(3'h4), .dev_rate(sdp_rate), .frame_ok,
        .frame_bad, .polls);
    // Compare one value and count it
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Register write, one cycle request
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Register read, answer one cycle after the request is taken
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1;
        chk("reg_rvalid", 16'h0001, {15'h0, reg_rvalid});
        chk("reg_rdata", e, reg_rdata);
    endtask
    task automatic give_verdict;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(MSSC_OFF_STATUS_LO, 16'h0020);
        @(posedge clk);
        init_busy <= 1'b0;
        st <= 11'h000;
        #1;
        chk("sdp_rate", 16'h0001, {13'h0, sdp_rate});
        chk("sdp_reply_en", 16'h0000, {15'h0, sdp_reply_en});
        rd(MSSC_OFF_BITRATE_CUR, 16'h0000);
        @(posedge clk);
        go <= 1'b1;
        for (n = 0; n < 200 && sdp_reply_en !== 1'b1; n++) @(posedge clk);
        #1;
        chk("polls", 16'h0004, polls[15:0]);
        chk("sdp_reply_en", 16'h0001, {15'h0, sdp_reply_en});
        rd(MSSC_OFF_BITRATE_CUR, 16'h0004);
        // Walk one status source at a time; bit 5 stays as captured at init
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            st <= 11'h001 << i;
            ex = (32'h0000_0001 << (i < 8 ? i : i + 6)) | 32'h0000_0020;
            rd(MSSC_OFF_STATUS_LO, ex[15:0]);
            rd(MSSC_OFF_STATUS_HI, ex[31:16]);
        end
        @(posedge clk);
        st <= 11'h000;
        foreach (rows[i]) begin
            if (rows[i].we) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk("sdp_node_addr", 16'h0001, {8'h0, sdp_node_addr});
        // Each parity code with a fixed rate, applied through the reset command
        for (int i = 0; i < 3; i++) begin
            wr(MSSC_OFF_PARITY_SEL, 16'(i));
            wr(MSSC_OFF_BITRATE_SEL, 16'(i + 4));
            wr(MSSC_OFF_OPMODE, 16'h0003);
            #1;
            chk("module_reset", 16'h0001, {15'h0, module_reset});
            repeat (4) @(posedge clk);
            #1;
            chk("sdp_parity", 16'(i == 2 ? 3 : i), {14'h0, sdp_parity});
            chk("sdp_two_stop", 16'(i == 2), {15'h0, sdp_two_stop});
            chk("sdp_rate", 16'(i + 4), {13'h0, sdp_rate});
            rd(MSSC_OFF_BITRATE_CUR, 16'(i + 4));
        end
        chk("sdp_node_addr", 16'h00F7, {8'h0, sdp_node_addr});
        give_verdict;
    end
endmodule // test_module_status_serial_config_regs
